// *** core/rail_ctrl_consts.svh ***
// constants for the three step-down rail control registers
// assumes inclusion by bare name from core design files
`ifndef RAIL_CTRL_CONSTS_SVH
`define RAIL_CTRL_CONSTS_SVH
`define RAIL4_CONTROL_OFS   8'h25
`define RAIL5_CONTROL_OFS   8'h26
`define RAIL6_CONTROL_OFS   8'h27
`define SLEEP_SEL_HI        5
`define SLEEP_SEL_LO        4
`define RSVD_HI             3
`define RSVD_LO             2
`define PWM_FORCE_BIT       1
`define SOFT_GATE_BIT       0
`define SLEEP_SEL_OFF       2'h0
`define SLEEP_SEL_ON        2'h3
`define RSVD_ONES           2'h3
`define CTRL_RESET_DEFAULT  8'h0f
`define UNMAPPED_READ       8'h00
`define STORED_HI           5
`define RO_TOP_HI           7
`define RO_TOP_LO           6
`define RO_TOP_ZERO         2'h0
`define VOLT_RESET          7'h00
`define SLEEP_PIN_IDLE      2'h3
`define PIN_EN_RESET        3'h0
`endif

// *** core/rail_ctrl_pkg.sv ***
// types shared by the rail control register bank
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package rail_ctrl_pkg;
  typedef logic [7:0] regByte_t;
  typedef logic [6:0] voltCode_t;
  typedef enum logic {SLEEP_PIN_A, SLEEP_PIN_B} sleepPin_t;
endpackage : rail_ctrl_pkg
`default_nettype wire

// *** core/rail_ctrl_slice.sv ***
// one rail's control register and its output steering
// assumes writes arrive as one-cycle strobes on mclk
`include "rail_ctrl_consts.svh"
`default_nettype none
module rail_ctrl_slice
  import rail_ctrl_pkg::*;
#(
  parameter regByte_t RESET_VALUE = `CTRL_RESET_DEFAULT
) (
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      wrHit,
  input  wire regByte_t  wrData,
  input  wire logic      sleepPinLow,
  input  wire logic      pinEnable,
  input  wire voltCode_t normalCode,
  input  wire voltCode_t sleepCode,
  output regByte_t       ctrlValue,
  output voltCode_t      voltCode,
  output logic           pwmForce,
  output logic           railOn
);
  // =====================================================
  // register: only bits 5:0 are stored
  logic [`STORED_HI:0] ctrl_ff;
  logic [`STORED_HI:0] nxt_ctrl;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wrHit) begin
      nxt_ctrl = wrData[`STORED_HI:0]; // bits 7:6 dropped
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_ff <= RESET_VALUE[`STORED_HI:0];
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // =====================================================
  // outputs: mixed sleep codes act as off, the safe reading
  logic      sleepOn;
  voltCode_t voltCode_ff;
  voltCode_t nxt_voltCode;
  logic      pwmForce_ff;
  logic      nxt_pwmForce;
  logic      railOn_ff;
  logic      nxt_railOn;
  assign sleepOn = (ctrl_ff[`SLEEP_SEL_HI:`SLEEP_SEL_LO] == `SLEEP_SEL_ON);
  assign ctrlValue = {`RO_TOP_ZERO, ctrl_ff};

  // next output values, registered so every data output is a flop
  always_comb begin
    nxt_voltCode = (sleepOn && sleepPinLow) ? sleepCode
                                            : normalCode;
    nxt_pwmForce = ctrl_ff[`PWM_FORCE_BIT];
    nxt_railOn   = ctrl_ff[`SOFT_GATE_BIT] & pinEnable;
  end

  // output registers only
  always_ff @(posedge mclk) begin
    if (reset) begin
      voltCode_ff <= `VOLT_RESET;
      pwmForce_ff <= 1'b0;
      railOn_ff   <= 1'b0;
    end else begin
      voltCode_ff <= nxt_voltCode;
      pwmForce_ff <= nxt_pwmForce;
      railOn_ff   <= nxt_railOn;
    end
  end
  assign voltCode = voltCode_ff;
  assign pwmForce = pwmForce_ff;
  assign railOn   = railOn_ff;
endmodule : rail_ctrl_slice
`default_nettype wire

// *** core/buck_rail_control_regs.sv ***
// control register bank for three step-down rails
// assumes an upstream serial host decoder giving byte strobes on mclk
// and asynchronous control pins that are synchronised here
// factory straps for reset images and sleep pins arrive as parameters
//
// Behaviour
// - three alike registers, consecutive offsets, per rail
// - select 00 always uses normal voltage code
// - select 11 uses sleep code while pin low
// - sleep pin choice fixed by factory configuration
// - bit 1 chooses automatic or forced PWM
// - bit 0 low forces rail off always
// - third register has the same field meanings
`include "rail_ctrl_consts.svh"
`default_nettype none
module buck_rail_control_regs
  import rail_ctrl_pkg::*;
#(
  parameter regByte_t  RAIL4_RESET = `CTRL_RESET_DEFAULT,
  parameter regByte_t  RAIL5_RESET = `CTRL_RESET_DEFAULT,
  parameter regByte_t  RAIL6_RESET = `CTRL_RESET_DEFAULT,
  parameter sleepPin_t RAIL4_PIN   = SLEEP_PIN_A,
  parameter sleepPin_t RAIL5_PIN   = SLEEP_PIN_A,
  parameter sleepPin_t RAIL6_PIN   = SLEEP_PIN_A
) (
  input  wire logic      mclk,
  input  wire logic      reset,
  input  wire logic      regWrite,
  input  wire logic      regRead,
  input  wire regByte_t  regAddr,
  input  wire regByte_t  regWrData,
  output regByte_t       regRdData,
  input  wire logic      controlInput3SleepA,
  input  wire logic      controlInput6SleepB,
  input  wire logic [2:0] railPinEnable,
  input  wire voltCode_t rail4NormalVoltageCode,
  input  wire voltCode_t rail4SleepVoltageCode,
  input  wire voltCode_t rail5NormalVoltageCode,
  input  wire voltCode_t rail5SleepVoltageCode,
  input  wire voltCode_t rail6NormalVoltageCode,
  input  wire voltCode_t rail6SleepVoltageCode,
  output voltCode_t      rail4VoltageCode,
  output voltCode_t      rail5VoltageCode,
  output voltCode_t      rail6VoltageCode,
  output logic [2:0]     railPwmForce,
  output logic [2:0]     railOn
);
  // =====================================================
  // elaboration checks on the factory reset images
  // an image that sets the read-only pair, clears the reserved pair or
  // holds a mixed sleep code is a state that legal software could never
  // write, so such a strap set is refused before anything is built;
  // at run time the reserved bits are stored just as they are written
  function automatic logic resetLegal(input regByte_t image);
    logic topClear;
    logic rsvdSet;
    logic selPure;
    topClear   = (image[`RO_TOP_HI:`RO_TOP_LO] == `RO_TOP_ZERO);
    rsvdSet    = (image[`RSVD_HI:`RSVD_LO] == `RSVD_ONES);
    selPure    = (image[`SLEEP_SEL_HI:`SLEEP_SEL_LO] == `SLEEP_SEL_OFF) ||
                 (image[`SLEEP_SEL_HI:`SLEEP_SEL_LO] == `SLEEP_SEL_ON);
    resetLegal = topClear && rsvdSet && selPure;
  endfunction : resetLegal

  if (!resetLegal(RAIL4_RESET)) begin : g_bad_rail4_reset
    $error("rail4 reset image is not a legal register value");
  end
  if (!resetLegal(RAIL5_RESET)) begin : g_bad_rail5_reset
    $error("rail5 reset image is not a legal register value");
  end
  if (!resetLegal(RAIL6_RESET)) begin : g_bad_rail6_reset
    $error("rail6 reset image is not a legal register value");
  end

  // =====================================================
  // pin synchronisers: pins come from outside mclk
  // two stages per pin and only the second stage is read anywhere, so a
  // metastable first stage never fans out; the cost is two cycles of
  // latency on every pin, three counting the output register
  logic [1:0] sleepMeta_ff;
  logic [1:0] sleepSync_ff;
  logic [2:0] enMeta_ff;
  logic [2:0] enSync_ff;
  logic [1:0] nxt_sleepMeta;
  logic [1:0] nxt_sleepSync;
  logic [2:0] nxt_enMeta;
  logic [2:0] nxt_enSync;

  // next values: every pin moves one stage along each cycle
  always_comb begin
    nxt_sleepMeta = {controlInput6SleepB, controlInput3SleepA};
    nxt_sleepSync = sleepMeta_ff;
    nxt_enMeta    = railPinEnable;
    nxt_enSync    = enMeta_ff;
  end

  // sleep stages reset to the idle high level, so no false sleep
  // request reaches a rail in the first cycles after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      sleepMeta_ff <= `SLEEP_PIN_IDLE;
      sleepSync_ff <= `SLEEP_PIN_IDLE;
      enMeta_ff    <= `PIN_EN_RESET;
      enSync_ff    <= `PIN_EN_RESET;
    end else begin
      sleepMeta_ff <= nxt_sleepMeta;
      sleepSync_ff <= nxt_sleepSync;
      enMeta_ff    <= nxt_enMeta;
      enSync_ff    <= nxt_enSync;
    end
  end

  // factory strap choice of sleep pin, low means sleep
  // the strap is a parameter, not a register bit: software can switch
  // sleep on or off but can never move a rail onto the other pin
  function automatic logic pinLow(input sleepPin_t sel,
                                  input logic [1:0] pins);
    pinLow = (sel == SLEEP_PIN_A) ? ~pins[0] : ~pins[1];
  endfunction : pinLow

  // =====================================================
  // address decode and read mux
  // one decode function feeds both the write strobes and the read mux,
  // so a write and a read can never disagree about which offset
  // belongs to which rail; anything outside the three offsets matches
  // nothing and so writes nowhere and reads as zero
  function automatic logic [2:0] railSelect(input regByte_t addr);
    railSelect = {(addr == `RAIL6_CONTROL_OFS),
                  (addr == `RAIL5_CONTROL_OFS),
                  (addr == `RAIL4_CONTROL_OFS)};
  endfunction : railSelect

  logic [2:0] addrMatch;
  logic [2:0] hit;
  regByte_t   ctrl4;
  regByte_t   ctrl5;
  regByte_t   ctrl6;
  assign addrMatch = railSelect(regAddr);
  assign hit       = {3{regWrite}} & addrMatch; // unmapped writes fall away

  // read data is registered and holds until the next read; a read in
  // the same cycle as a write to that register returns the old value
  regByte_t nxt_rd;
  regByte_t rd_ff;
  always_comb begin
    nxt_rd = rd_ff;
    if (regRead) begin
      if (addrMatch[0]) begin
        nxt_rd = ctrl4;
      end else if (addrMatch[1]) begin
        nxt_rd = ctrl5;
      end else if (addrMatch[2]) begin
        nxt_rd = ctrl6;
      end else begin
        nxt_rd = `UNMAPPED_READ; // unmapped offsets read as zero
      end
    end
  end

  // read data register only
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_ff <= `UNMAPPED_READ;
    end else begin
      rd_ff <= nxt_rd;
    end
  end
  assign regRdData = rd_ff;

  // =====================================================
  // three identical slices, each touches only its own rail
  // a write strobe reaches one slice only, so a stray offset can never
  // disturb a neighbouring rail; the price is three copies of the
  // output registers rather than one shared set
  // the sleep pin for each rail is picked here from its strap
  rail_ctrl_slice #(.RESET_VALUE(RAIL4_RESET)) rail4 (
    .mclk        (mclk),
    .reset       (reset),
    .wrHit       (hit[0]),
    .wrData      (regWrData),
    .sleepPinLow (pinLow(RAIL4_PIN, sleepSync_ff)),
    .pinEnable   (enSync_ff[0]),
    .normalCode  (rail4NormalVoltageCode),
    .sleepCode   (rail4SleepVoltageCode),
    .ctrlValue   (ctrl4),
    .voltCode    (rail4VoltageCode),
    .pwmForce    (railPwmForce[0]),
    .railOn      (railOn[0])
  );
  rail_ctrl_slice #(.RESET_VALUE(RAIL5_RESET)) rail5 (
    .mclk        (mclk),
    .reset       (reset),
    .wrHit       (hit[1]),
    .wrData      (regWrData),
    .sleepPinLow (pinLow(RAIL5_PIN, sleepSync_ff)),
    .pinEnable   (enSync_ff[1]),
    .normalCode  (rail5NormalVoltageCode),
    .sleepCode   (rail5SleepVoltageCode),
    .ctrlValue   (ctrl5),
    .voltCode    (rail5VoltageCode),
    .pwmForce    (railPwmForce[1]),
    .railOn      (railOn[1])
  );
  rail_ctrl_slice #(.RESET_VALUE(RAIL6_RESET)) rail6 (
    .mclk        (mclk),
    .reset       (reset),
    .wrHit       (hit[2]),
    .wrData      (regWrData),
    .sleepPinLow (pinLow(RAIL6_PIN, sleepSync_ff)),
    .pinEnable   (enSync_ff[2]),
    .normalCode  (rail6NormalVoltageCode),
    .sleepCode   (rail6SleepVoltageCode),
    .ctrlValue   (ctrl6),
    .voltCode    (rail6VoltageCode),
    .pwmForce    (railPwmForce[2]),
    .railOn      (railOn[2])
  );
endmodule : buck_rail_control_regs
`default_nettype wire

// *** verif/buck_rail_control_regs_checker.sv ***
// assertions on the rail control register bank ports
// assumes binding to buck_rail_control_regs with default pin straps
`default_nettype none
module buck_rail_control_regs_checker
  import rail_ctrl_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire regByte_t   regAddr,
  input wire regByte_t   regWrData,
  input wire regByte_t   regRdData,
  input wire logic       controlInput3SleepA,
  input wire logic [2:0] railPinEnable,
  input wire logic [2:0] railPwmForce,
  input wire logic [2:0] railOn,
  input wire voltCode_t  rail4NormalVoltageCode,
  input wire voltCode_t  rail4SleepVoltageCode,
  input wire voltCode_t  rail4VoltageCode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================
  // steps of a rail-4 write
  sequence wr4(logic [1:0] s);
    regWrite && regAddr == 8'h25 && regWrData[5:4] == s;
  endsequence
  // pin must hold 3 edges: two sync stages plus output flop
  sequence sleepHeld;
    wr4(2'h3) ##1 (!regWrite && !controlInput3SleepA)[*3];
  endsequence
  a_pwm_rail4: assert property (regWrite && regAddr == 8'h25 |->
    ##2 railPwmForce[0] == $past(regWrData[1], 2)) else $error("pwm4");
  a_pwm_rail6: assert property (regWrite && regAddr == 8'h27 |->
    ##2 railPwmForce[2] == $past(regWrData[1], 2)) else $error("pwm6");
  a_gate_off: assert property (regWrite && regAddr == 8'h26 &&
    !regWrData[0] |-> ##2 !railOn[1]) else $error("gate off");
  a_gate_pin: assert property (railOn[0] && !$past(reset, 3) |->
    $past(railPinEnable[0], 3)) else $error("pin enable");
  a_sel_normal: assert property (wr4(2'h0) |-> ##2
    rail4VoltageCode == $past(rail4NormalVoltageCode)) else $error("normal");
  a_sel_sleep: assert property (sleepHeld |-> ##1
    rail4VoltageCode == $past(rail4SleepVoltageCode)) else $error("sleep");
  a_top_zero: assert property (regRead |-> ##1
    regRdData[7:6] == 2'h0) else $error("top bits");
  a_unmapped_read: assert property (regRead && (regAddr < 8'h25 ||
    regAddr > 8'h27) |-> ##1 regRdData == 8'h00) else $error("unmapped");
endmodule : buck_rail_control_regs_checker
`default_nettype wire

// *** verif/tb_buck_rail_control_regs.sv ***
// self-checking bench for the rail control register bank
// assumes design and checker compiled first, default factory straps
`default_nettype none
module tb_buck_rail_control_regs
  import rail_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, reset, regWrite, regRead;
  logic       controlInput3SleepA, controlInput6SleepB;
  logic [2:0] railPinEnable, railPwmForce, railOn;
  regByte_t   regAddr, regWrData, regRdData;
  voltCode_t  rail4NormalVoltageCode, rail4SleepVoltageCode;
  voltCode_t  rail5NormalVoltageCode, rail5SleepVoltageCode;
  voltCode_t  rail6NormalVoltageCode, rail6SleepVoltageCode;
  voltCode_t  rail4VoltageCode, rail5VoltageCode, rail6VoltageCode;
  int         n_errors, num_checks;
  buck_rail_control_regs u_dut (.mclk, .reset, .regWrite, .regRead,
    .regAddr, .regWrData, .regRdData, .controlInput3SleepA,
    .controlInput6SleepB, .railPinEnable, .rail4NormalVoltageCode,
    .rail4SleepVoltageCode, .rail5NormalVoltageCode, .rail5SleepVoltageCode,
    .rail6NormalVoltageCode, .rail6SleepVoltageCode, .rail4VoltageCode,
    .rail5VoltageCode, .rail6VoltageCode, .railPwmForce, .railOn);
  // ==========================================================
  // shared bus and compare tasks
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input regByte_t a, input regByte_t d);
    @(posedge mclk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr
  task rd(input regByte_t a, input regByte_t exp);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    chk(regRdData, exp);
  endtask : rd
  // pins need 3 edges, so 5 leaves margin
  task settle;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
  endtask : settle
  // ==========================================================
  // scenarios
  task field_masks;
    for (int i = 0; i < 3; i++) rd(regByte_t'(8'h25 + i), 8'h0f);
    for (int i = 0; i < 3; i++) wr(regByte_t'(8'h25 + i), 8'hff);
    for (int i = 0; i < 3; i++) rd(regByte_t'(8'h25 + i), 8'h3f);
    wr(8'h24, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h28, 8'h00);
  endtask : field_masks
  task mode_gate;
    wr(8'h27, 8'h0e);
    wr(8'h26, 8'h0c);
    settle;
    chk({5'h0, railPwmForce}, 8'h05);
    chk({5'h0, railOn}, 8'h01);
    @(posedge mclk);
    railPinEnable <= 3'h6;
    settle;
    chk({5'h0, railOn}, 8'h00);
    @(posedge mclk);
    railPinEnable <= 3'h7;
  endtask : mode_gate
  task sleep_steer;
    @(posedge mclk);
    controlInput3SleepA <= 1'b0;
    wr(8'h27, 8'h3f);
    wr(8'h25, 8'h3d);
    settle;
    chk({1'b0, rail4VoltageCode}, 8'h22);
    chk({1'b0, rail5VoltageCode}, 8'h33);
    chk({1'b0, rail6VoltageCode}, 8'h66);
    @(posedge mclk);
    controlInput3SleepA <= 1'b1;
    controlInput6SleepB <= 1'b0;
    settle;
    chk({1'b0, rail4VoltageCode}, 8'h11);
    chk({1'b0, rail6VoltageCode}, 8'h55);
    @(posedge mclk);
    controlInput3SleepA <= 1'b0;
    wr(8'h25, 8'h0d);
    settle;
    chk({1'b0, rail4VoltageCode}, 8'h11);
    chk({1'b0, rail6VoltageCode}, 8'h66);
  endtask : sleep_steer
  task stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // clock, reset and stimulus
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    {reset, regWrite, regRead, regAddr, regWrData} = {3'b100, 16'h0};
    {controlInput3SleepA, controlInput6SleepB, railPinEnable} = 5'h1f;
    rail4NormalVoltageCode = 7'h11;
    rail4SleepVoltageCode  = 7'h22;
    rail5NormalVoltageCode = 7'h33;
    rail5SleepVoltageCode  = 7'h44;
    rail6NormalVoltageCode = 7'h55;
    rail6SleepVoltageCode  = 7'h66;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    field_masks;
    mode_gate;
    sleep_steer;
    stop_test;
  end
  // tests take about 70 cycles; far past that means a hang
  initial begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    stop_test;
  end
endmodule : tb_buck_rail_control_regs
bind buck_rail_control_regs buck_rail_control_regs_checker u_chk (.mclk,
  .reset, .regWrite, .regRead, .regAddr, .regWrData, .regRdData,
  .controlInput3SleepA, .railPinEnable, .railPwmForce, .railOn,
  .rail4NormalVoltageCode, .rail4SleepVoltageCode, .rail4VoltageCode);
`default_nettype wire
